// ### verilog/acc_pkg.sv
// Package for the conversion controller: register map, fields, codes, timing
package acc_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
  localparam logic [1:0] ADDR_RESULT = 2'h1;
  localparam logic [1:0] ADDR_CLOCK_SELECT = 2'h2;

  // Control/status field positions
  localparam int CS_DONE_BIT = 7;
  localparam int CS_IRQ_EN_BIT = 6;
  localparam int CS_CONT_BIT = 5;
  localparam int CS_CHAN_MSB = 4;

  // Clock select field positions
  localparam int CK_PRESCALE_MSB = 7;
  localparam int CK_PRESCALE_LSB = 5;
  localparam int CK_SRC_BIT = 4;

  // Reset values: done, irq enable, continuous clear; channel powered off
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h1f;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] RESERVED_RESULT = 8'h00;

  // Channel codes
  localparam logic [4:0] CHAN_LAST_PORT = 5'h05;
  localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW = 5'h1e;
  localparam logic [4:0] CHAN_POWER_OFF = 5'h1f;
  localparam int PORT_CHANNELS = 6;

  // Converter clocks per conversion
  localparam logic [4:0] CONV_CLOCKS = 5'h10;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_ARMED = 3'b010,
    ACC_CONVERT = 3'b100
  } acc_state_t;

  // Register bus request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acc_bus_req_t;

  // Towards the analog multiplexer and comparator
  typedef struct packed {
    logic [4:0] chan;
    logic powered;
    logic sample;
    logic [7:0] trial;
  } acc_analog_t;

endpackage

// ### verilog/acc_conversion_ctrl.sv
// Conversion controller for an 8-bit successive-approximation converter
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps

module acc_conversion_ctrl
  import acc_pkg::*;
#(
  parameter int DATA_BITS = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire acc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Clock sources, same domain as sys_clk, used as enables
  input wire logic bus_clk_tick,
  input wire logic xtal_clk_tick,
  // Low power modes
  input wire logic stop_mode,
  input wire logic wait_mode,
  // Analog side
  output acc_analog_t analog_o,
  input wire logic comp_above,
  // Port pin override and interrupt
  output logic [PORT_CHANNELS-1:0] port_chan_force,
  output logic conv_irq,
  output logic wake_req
);

  initial begin
    if (DATA_BITS != 8) begin
      $error("acc_conversion_ctrl supports only DATA_BITS of 8");
    end
  end

  // Comparator comes from the analog domain, so it is synchronised
  logic comp_meta_q;
  logic comp_sync_q;

  acc_state_t state_q;
  acc_state_t state_d;
  logic conv_done_q;
  logic conv_irq_en_q;
  logic cont_conv_q;
  logic [4:0] chan_sel_q;
  logic [2:0] clk_prescale_q;
  logic clk_src_sel_q;
  logic [7:0] result_q;
  logic [7:0] sar_q;
  logic [4:0] step_q;
  logic [3:0] div_cnt_q;
  logic irq_q;
  logic first_done_q;
  logic [7:0] rdata_q;

  function automatic logic [3:0] div_mask(input logic [2:0] code);
    logic [3:0] m;
    m = 4'hf;
    if (!code[2]) begin
      case (code[1:0])
        2'b00: m = 4'h0;
        2'b01: m = 4'h1;
        2'b10: m = 4'h3;
        default: m = 4'h7;
      endcase
    end
    return m;
  endfunction

  // Decode
  wire logic wr_cs = bus_req.wr && (bus_req.addr == ADDR_CTRL_STATUS);
  wire logic wr_ck = bus_req.wr && (bus_req.addr == ADDR_CLOCK_SELECT);
  wire logic rd_res = bus_req.rd && (bus_req.addr == ADDR_RESULT);
  wire logic powered = (chan_sel_q != CHAN_POWER_OFF);
  wire logic active = powered && !stop_mode;
  wire logic src_tick = clk_src_sel_q ? bus_clk_tick : xtal_clk_tick;
  wire logic conv_tick = src_tick && ((div_cnt_q & div_mask(clk_prescale_q)) == 4'h0);
  wire logic reserved_chan = (chan_sel_q > CHAN_LAST_PORT) && (chan_sel_q < CHAN_REF_HIGH);
  wire logic last_step = (step_q == CONV_CLOCKS - 5'h01);
  wire logic finish = (state_q == ACC_CONVERT) && conv_tick && last_step && active;
  wire logic [2:0] bit_idx = 3'(5'h07 - step_q[4:0]);
  wire logic [7:0] sar_kept = comp_sync_q ? sar_q : (sar_q & ~(8'h01 << bit_idx));
  // Next trial bit sits one below the bit just decided
  wire logic [2:0] next_idx = 3'(5'h06 - step_q[4:0]);
  wire logic [7:0] sar_trial = (step_q < 5'h07) ? (sar_kept | (8'h01 << next_idx)) :
                               (step_q == 5'h07) ? sar_kept : sar_q;
  wire logic [7:0] final_val = reserved_chan ? RESERVED_RESULT : sar_q;
  wire logic irq_set = finish && conv_irq_en_q && !conv_done_q;
  wire logic done_set = finish && !conv_irq_en_q && (!cont_conv_q || !first_done_q);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ACC_IDLE: begin
        if (wr_cs) begin
          state_d = ACC_ARMED;
        end
      end
      ACC_ARMED: begin
        if (active && conv_tick) begin
          state_d = ACC_CONVERT;
        end
      end
      ACC_CONVERT: begin
        if (finish) begin
          state_d = cont_conv_q ? ACC_CONVERT : ACC_IDLE;
        end
      end
      default: state_d = ACC_IDLE;
    endcase
    if (!active && state_q == ACC_CONVERT) begin
      state_d = ACC_ARMED;
    end
    if (wr_cs) begin
      state_d = ACC_ARMED;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else if (clk_en) begin
      comp_meta_q <= comp_above;
      comp_sync_q <= comp_meta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ACC_IDLE;
      step_q <= 5'h00;
      sar_q <= 8'h00;
      div_cnt_q <= 4'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (src_tick) begin
        div_cnt_q <= div_cnt_q + 4'h1;
      end
      if (state_q != ACC_CONVERT || state_d != ACC_CONVERT || finish) begin
        step_q <= 5'h00;
        sar_q <= 8'h80;
      end else if (conv_tick) begin
        step_q <= step_q + 5'h01;
        sar_q <= sar_trial;
      end
    end
  end

  // Register file
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_done_q <= CTRL_STATUS_RESET[CS_DONE_BIT];
      conv_irq_en_q <= CTRL_STATUS_RESET[CS_IRQ_EN_BIT];
      cont_conv_q <= CTRL_STATUS_RESET[CS_CONT_BIT];
      chan_sel_q <= CTRL_STATUS_RESET[CS_CHAN_MSB:0];
      clk_prescale_q <= CLOCK_SELECT_RESET[CK_PRESCALE_MSB:CK_PRESCALE_LSB];
      clk_src_sel_q <= CLOCK_SELECT_RESET[CK_SRC_BIT];
      result_q <= RESULT_RESET;
      irq_q <= 1'b0;
      first_done_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_cs) begin
        conv_irq_en_q <= bus_req.wdata[CS_IRQ_EN_BIT];
        cont_conv_q <= bus_req.wdata[CS_CONT_BIT];
        chan_sel_q <= bus_req.wdata[CS_CHAN_MSB:0];
        first_done_q <= 1'b0;
      end else if (finish) begin
        first_done_q <= 1'b1;
      end
      // Hardware set wins over the clear from a write or read
      if (done_set) begin
        conv_done_q <= 1'b1;
      end else if (wr_cs) begin
        conv_done_q <= conv_irq_en_q ? bus_req.wdata[CS_DONE_BIT] : 1'b0;
      end else if (rd_res && !conv_irq_en_q) begin
        conv_done_q <= 1'b0;
      end
      if (wr_ck) begin
        clk_prescale_q <= bus_req.wdata[CK_PRESCALE_MSB:CK_PRESCALE_LSB];
        clk_src_sel_q <= bus_req.wdata[CK_SRC_BIT];
      end
      if (finish) begin
        result_q <= final_val;
      end
      if (irq_set) begin
        irq_q <= 1'b1;
      end else if (wr_cs || rd_res) begin
        irq_q <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe
  wire logic [7:0] cs_view = {conv_done_q, conv_irq_en_q, cont_conv_q, chan_sel_q};
  wire logic [7:0] ck_view = {clk_prescale_q, clk_src_sel_q, 4'h0};
  wire logic [7:0] rd_mux = (bus_req.addr == ADDR_CTRL_STATUS) ? cs_view :
                            (bus_req.addr == ADDR_RESULT) ? result_q :
                            (bus_req.addr == ADDR_CLOCK_SELECT) ? ck_view : 8'h00;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // Port override decode, only for the six port channels
  genvar gi;
  generate
    for (gi = 0; gi < PORT_CHANNELS; gi++) begin : g_force
      assign port_chan_force[gi] = powered && (chan_sel_q == 5'(gi));
    end
  endgenerate

  assign bus_rdata = rdata_q;
  assign conv_irq = irq_q;
  assign wake_req = irq_q && wait_mode;
  assign analog_o.chan = chan_sel_q;
  assign analog_o.powered = active;
  assign analog_o.sample = (state_q == ACC_CONVERT);
  assign analog_o.trial = sar_q;

endmodule

// ### test/acc_conversion_ctrl_assertions.sv
// Port checker for the conversion controller, bound to its top module
`timescale 1ns/100ps
module acc_checker
  import acc_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port and modes
  input wire acc_bus_req_t bus_req,
  input wire logic stop_mode,
  input wire logic wait_mode,
  // Converter side and requests
  input wire acc_analog_t analog_o,
  input wire logic [PORT_CHANNELS-1:0] port_chan_force,
  input wire logic conv_irq,
  input wire logic wake_req
);
  logic irq_en_q;
  logic cont_q;
  wire cs_wr = clk_en && bus_req.wr && bus_req.addr == ADDR_CTRL_STATUS;
  wire res_rd = clk_en && bus_req.rd && bus_req.addr == ADDR_RESULT;
  // Shadow of the control bits as software wrote them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_q <= 1'h0;
      cont_q <= 1'h0;
    end else if (cs_wr) begin
      irq_en_q <= bus_req.wdata[CS_IRQ_EN_BIT];
      cont_q <= bus_req.wdata[CS_CONT_BIT];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_sw_clear;
    cs_wr || res_rd;
  endsequence
  sequence s_stays_idle;
    !analog_o.sample [*3];
  endsequence
  a_wake_is_irq: assert property (wake_req == (conv_irq && wait_mode)) else $error("wake bad");
  a_off_idle: assert property (analog_o.chan == CHAN_POWER_OFF |-> ##[0:2]
    !(analog_o.powered || analog_o.sample)) else $error("off but active");
  a_stop_aborts: assert property (stop_mode |-> ##[0:2] !analog_o.sample) else $error("stop ignored");
  a_force_pin: assert property (port_chan_force == ((analog_o.powered &&
    analog_o.chan <= CHAN_LAST_PORT) ? 6'h01 << analog_o.chan : 6'h00)) else $error("force bad");
  a_irq_drop: assert property (s_sw_clear |=> !conv_irq) else $error("irq kept");
  a_irq_holds: assert property (conv_irq && !cs_wr && !res_rd |=> conv_irq) else $error("irq lost");
  a_irq_needs_en: assert property ($rose(conv_irq) |-> irq_en_q) else $error("irq unasked");
  a_single_once: assert property ($fell(analog_o.sample) && !cont_q && !stop_mode && !cs_wr
    |=> s_stays_idle) else $error("extra conversion");
endmodule
bind acc_conversion_ctrl acc_checker u_acc_checker (.sys_clk, .arst_n, .clk_en, .bus_req, .stop_mode,
  .wait_mode, .analog_o, .port_chan_force, .conv_irq, .wake_req);

// ### test/acc_analog_model.sv
// Stand-in for the input multiplexer and comparator
`timescale 1ns/100ps
module acc_analog_model
  import acc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Converter side
  input wire acc_analog_t analog_o,
  output logic comp_above
);
  logic [7:0] vin;
  logic t_q = 1'h0;
  // Reserved codes see a live level, so a zero result proves the override
  assign vin = analog_o.chan == CHAN_REF_HIGH ? 8'hff : analog_o.chan == CHAN_REF_LOW ? 8'h00 :
    analog_o.chan <= CHAN_LAST_PORT ? {analog_o.chan, 3'h4} : 8'hc3;
  always @(posedge sys_clk) t_q <= ~t_q;
  // Unpowered comparator output wanders
  assign comp_above = analog_o.powered ? vin >= analog_o.trial : t_q;
endmodule

// ### test/testbench.sv
// Self-checking bench for the conversion controller
`timescale 1ns/100ps
module testbench;
  import acc_pkg::*;
  logic sys_clk = 1'h0, arst_n = 1'h0, clk_en = 1'h1, stop_mode = 1'h0, wait_mode = 1'h0;
  logic bus_clk_tick = 1'h0, xtal_clk_tick = 1'h0, comp_above, conv_irq, wake_req;
  acc_bus_req_t bus_req = '0;
  acc_analog_t analog_o;
  logic [7:0] bus_rdata, d;
  logic [5:0] port_chan_force;
  logic [1:0] ph = 2'h0;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  acc_conversion_ctrl u_acc_conversion_ctrl (.sys_clk, .arst_n, .clk_en, .bus_req, .bus_rdata, .bus_clk_tick,
    .xtal_clk_tick, .stop_mode, .wait_mode, .analog_o, .comp_above, .port_chan_force, .conv_irq, .wake_req);
  acc_analog_model u_acc_analog_model (.sys_clk, .analog_o, .comp_above);
  always #2 sys_clk = ~sys_clk;
  // Crystal ticks every 4 cycles, bus ticks every 2
  always @(posedge sys_clk) begin
    ph <= ph + 2'h1;
    cyc <= cyc + 1;
    xtal_clk_tick <= ph == 2'h3;
    bus_clk_tick <= ph[0];
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  task complete_run();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus_req <= '{a, v, 1'h1, 1'h0};
    @(posedge sys_clk);
    bus_req.wr <= 1'h0;
  endtask
  task rd(input logic [1:0] a);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge sys_clk);
    bus_req.rd <= 1'h0;
    #1 d = bus_rdata;
  endtask
  task wait_done();
    for (int i = 0; i < 1200; i++) begin
      rd(ADDR_CTRL_STATUS);
      if (d[CS_DONE_BIT] === 1'h1) break;
    end
    chk(d[CS_DONE_BIT], 8'h01);
  endtask
  task t_reset();
    rd(ADDR_CTRL_STATUS);
    chk(d, CTRL_STATUS_RESET);
    rd(ADDR_CLOCK_SELECT);
    chk(d, CLOCK_SELECT_RESET);
    rd(ADDR_RESULT);
    chk(d, RESULT_RESET);
    rd(2'h3);
    chk(d, 8'h00);
    repeat (100) @(posedge sys_clk);
    chk(analog_o.sample, 8'h00);
  endtask
  task t_chan(input logic [4:0] c, input logic [7:0] e);
    wr(ADDR_CTRL_STATUS, {3'h0, c});
    wait_done();
    rd(ADDR_RESULT);
    chk(d, e);
    rd(ADDR_CTRL_STATUS);
    chk(d[CS_DONE_BIT], 8'h00);
    repeat (100) @(posedge sys_clk);
    chk(analog_o.sample, 8'h00);
  endtask
  task t_port();
    wr(ADDR_CTRL_STATUS, 8'h03);
    wait_done();
    chk(port_chan_force, 8'h08);
    rd(ADDR_RESULT);
  endtask
  task t_clock();
    int per, t0;
    for (int p = 0; p < 8; p++) begin
      // Clock changed only while idle
      wr(ADDR_CLOCK_SELECT, {p[2:0], p == 1, 4'h0});
      per = (p == 1 ? 2 : 4) * (p > 3 ? 16 : 1 << p);
      t0 = cyc;
      wr(ADDR_CTRL_STATUS, {3'h0, CHAN_REF_HIGH});
      wait_done();
      chk(cyc - t0 >= 16 * per && cyc - t0 <= 17 * per + 8, 8'h01);
      rd(ADDR_RESULT);
    end
    wr(ADDR_CLOCK_SELECT, 8'h00);
  endtask
  task t_cont();
    int n;
    n = 0;
    wr(ADDR_CTRL_STATUS, 8'h3d);
    wait_done();
    rd(ADDR_RESULT);
    chk(d, 8'hff);
    repeat (200) begin
      @(posedge sys_clk);
      n += analog_o.sample;
    end
    chk(n > 150, 8'h01);
    wr(ADDR_CTRL_STATUS, 8'h3e);
    repeat (300) @(posedge sys_clk);
    rd(ADDR_RESULT);
    chk(d, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'h1f);
  endtask
  task t_irq();
    int i;
    i = 0;
    @(posedge sys_clk);
    wait_mode <= 1'h1;
    wr(ADDR_CTRL_STATUS, 8'h5d);
    while (conv_irq !== 1'h1 && i < 600) begin
      @(posedge sys_clk);
      i++;
    end
    chk(conv_irq, 8'h01);
    chk(wake_req, 8'h01);
    rd(ADDR_CTRL_STATUS);
    chk(d, 8'h5d);
    rd(ADDR_RESULT);
    chk(conv_irq, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'hdd);
    repeat (600) @(posedge sys_clk);
    chk(conv_irq, 8'h00);
    rd(ADDR_CTRL_STATUS);
    chk(d, 8'hdd);
    wait_mode <= 1'h0;
    wr(ADDR_CTRL_STATUS, 8'h1f);
  endtask
  task t_stop();
    wr(ADDR_CTRL_STATUS, 8'h1d);
    repeat (20) @(posedge sys_clk);
    stop_mode <= 1'h1;
    repeat (40) @(posedge sys_clk);
    chk(analog_o.sample, 8'h00);
    rd(ADDR_CTRL_STATUS);
    chk(d[CS_DONE_BIT], 8'h00);
    stop_mode <= 1'h0;
    // Settling period before the result is trusted
    repeat (64) @(posedge sys_clk);
    wait_done();
    rd(ADDR_RESULT);
    chk(d, 8'hff);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
    t_reset();
    t_chan(CHAN_REF_HIGH, 8'hff);
    t_chan(CHAN_REF_LOW, 8'h00);
    t_chan(5'h06, RESERVED_RESULT);
    t_chan(5'h1c, RESERVED_RESULT);
    t_port();
    t_clock();
    t_cont();
    t_irq();
    t_stop();
    complete_run();
  end
endmodule
